/* core/gsc_dev.sv */
// sensor end: two-wire target, command decode, timed operations, response buffer
// Notes on behaviour
// - raw measure command starts measurement, 30 ms
// - raw result is one word plus crc
// - heater-off stops measuring, enters idle
// - default humidity and temperature keep compensation off
// - measure carries humidity then temperature words
// - self-test from idle returns to idle
// - self-test in measurement keeps hotplate on
// - self-test gives fixed pattern within 320 ms
// - serial number in idle: three words, 1 ms
// - idle within 0.6 ms after power-up
// - commands are two bytes, no crc
// - data moves as word plus crc byte
// - answer only target address 0x59
// - scl at most 400 kHz
// - master waits or polls read header
// - operation starts on command, nack while busy
// - when done, ack read, send msb first
// - master nack stops device sending
// - master ends read with nack, stop
// - data readable once, overread returns ones
// - crc-8 poly 0x31 init 0xff
// - master repeats measure about once per second
`timescale 1ns/100ps
`default_nettype none
module gsc_dev
  import gsc_pkg::*;
#(
  parameter int unsigned  MEAS_CYC   = MEAS_CYC_DEF,
  parameter int unsigned  SELF_CYC   = SELF_CYC_DEF,
  parameter int unsigned  SER_CYC    = SER_CYC_DEF,
  parameter int unsigned  HEAT_CYC   = HEAT_CYC_DEF,
  parameter int unsigned  PU_CYC     = PU_CYC_DEF,
  // arbitrary value
  parameter logic [47:0]  SERIAL_NUM = 48'h0000_1234_5678
) (
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  gsc_if.dev_mp            link,
  input  wire logic [15:0] raw_gas_signal_in,
  output logic             heater_on_out,
  output logic             comp_en_out,
  output logic             busy_out,
  output logic [15:0]      rh_word_out,
  output logic [15:0]      temp_word_out
);
  typedef enum {S_IDLE, S_ADDR, S_AACK, S_WR, S_WACK, S_RD, S_MACK, S_MNEXT, S_IGN} gsc_st_t;
  typedef enum {OP_NONE, OP_PU, OP_RAW, OP_SELF, OP_SER, OP_HEAT} gsc_op_t;

  logic        scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  gsc_st_t     st_q, st_d;
  gsc_op_t     op_q, op_d;
  logic [3:0]  bit_q, bit_d, wcnt_q, wcnt_d, rlen_q, rlen_d, ridx_q, ridx_d;
  logic [7:0]  sh_q, sh_d;
  logic [7:0]  wbuf_q [8];
  logic [7:0]  wbuf_d [8];
  logic [7:0]  resp_q [RESP_MAX];
  logic [7:0]  resp_d [RESP_MAX];
  logic        rw_q, rw_d, drv_q, drv_d, wrote_q, wrote_d, read_q, read_d;
  logic        meas_q, meas_d, comp_q, comp_d;
  logic [15:0] rh_q, rh_d, t_q, t_d, cmd, prm_rh, prm_t;
  logic [31:0] cnt_q, cnt_d;
  logic        start_ev, stop_ev, rise, fall, busy;
  logic [7:0]  nxt_byte;

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling
  always_ff @(posedge core_clk_in) begin
    scl_m_q <= link.scl_line;
    scl_s_q <= scl_m_q;
    scl_p_q <= scl_s_q;
    sda_m_q <= link.sda_line;
    sda_s_q <= sda_m_q;
    sda_p_q <= sda_s_q;
  end

  assign start_ev = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_ev  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign rise     = scl_s_q & ~scl_p_q;
  assign fall     = ~scl_s_q & scl_p_q;
  assign busy     = (cnt_q != 32'h0000_0000);
  assign cmd      = {wbuf_q[0], wbuf_q[1]};
  assign prm_rh   = {wbuf_q[2], wbuf_q[3]};
  assign prm_t    = {wbuf_q[5], wbuf_q[6]};
  // past the response every byte reads as ones
  assign nxt_byte = (ridx_q < rlen_q) ? resp_q[ridx_q] : FILL_BYTE;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_d    = st_q;
    op_d    = op_q;
    bit_d   = bit_q;
    wcnt_d  = wcnt_q;
    rlen_d  = rlen_q;
    ridx_d  = ridx_q;
    sh_d    = sh_q;
    wbuf_d  = wbuf_q;
    resp_d  = resp_q;
    rw_d    = rw_q;
    drv_d   = drv_q;
    wrote_d = wrote_q;
    read_d  = read_q;
    meas_d  = meas_q;
    comp_d  = comp_q;
    rh_d    = rh_q;
    t_d     = t_q;
    cnt_d   = cnt_q;
    // operation timer; the answer is built at the last count
    if (cnt_q == 32'h0000_0001) begin
      cnt_d  = 32'h0000_0000;
      op_d   = OP_NONE;
      ridx_d = 4'h0;
      case (op_q)
        OP_RAW: begin
          resp_d[0] = raw_gas_signal_in[15:8];
          resp_d[1] = raw_gas_signal_in[7:0];
          resp_d[2] = crc8(raw_gas_signal_in);
          rlen_d    = RESP_WORD1;
        end
        OP_SELF: begin
          resp_d[0] = SELF_PASS[15:8];
          resp_d[1] = SELF_PASS[7:0];
          resp_d[2] = crc8(SELF_PASS);
          rlen_d    = RESP_WORD1;
        end
        OP_SER: begin
          for (int i = 0; i < 3; i++) begin
            resp_d[3*i]   = SERIAL_NUM[47-16*i -: 8];
            resp_d[3*i+1] = SERIAL_NUM[39-16*i -: 8];
            resp_d[3*i+2] = crc8(SERIAL_NUM[47-16*i -: 16]);
          end
          rlen_d = RESP_WORD3;
        end
        OP_HEAT: rlen_d = 4'h0;
        default: ;
      endcase
    end else if (busy) begin
      cnt_d = cnt_q - 32'h0000_0001;
    end

    if (start_ev || stop_ev) begin
      // a read transfer consumes the response, even if cut short
      if (read_q) begin
        rlen_d = 4'h0;
      end
      if (wrote_q) begin
        if (wcnt_q == CMD_BYTES && cmd == CMD_SELF) begin
          op_d  = OP_SELF;
          cnt_d = SELF_CYC;
        end else if (wcnt_q == CMD_BYTES && cmd == CMD_HEAT_OFF) begin
          meas_d = 1'b0;
          op_d   = OP_HEAT;
          cnt_d  = HEAT_CYC;
        end else if (wcnt_q == CMD_BYTES && cmd == CMD_SERIAL && !meas_q) begin
          op_d  = OP_SER;
          cnt_d = SER_CYC;
        end else if (wcnt_q == CMD_PRM_BYTES && cmd == CMD_RAW
                     && crc8(prm_rh) == wbuf_q[4] && crc8(prm_t) == wbuf_q[7]) begin
          meas_d = 1'b1;
          rh_d   = prm_rh;
          t_d    = prm_t;
          comp_d = !(prm_rh == RH_DEFAULT && prm_t == T_DEFAULT);
          op_d   = OP_RAW;
          cnt_d  = MEAS_CYC;
        end
        // anything else leaves mode and answer untouched
      end
      st_d    = start_ev ? S_ADDR : S_IDLE;
      bit_d   = 4'h0;
      drv_d   = 1'b0;
      wcnt_d  = 4'h0;
      wrote_d = 1'b0;
      read_d  = 1'b0;
    end else begin
      case (st_q)
        S_ADDR: begin
          if (rise) begin
            sh_d  = {sh_q[6:0], sda_s_q};
            bit_d = bit_q + 4'h1;
          end else if (fall && bit_q == 4'h8) begin
            if (sh_q[7:1] == DEV_ADDR && !busy) begin
              drv_d = 1'b1;
              rw_d  = sh_q[0];
              st_d  = S_AACK;
            end else begin
              st_d = S_IGN;
            end
          end
        end
        S_AACK: begin
          if (fall) begin
            bit_d = 4'h0;
            if (rw_q) begin
              sh_d   = nxt_byte;
              drv_d  = ~nxt_byte[7];
              ridx_d = (ridx_q < RESP_WORD3) ? ridx_q + 4'h1 : ridx_q;
              read_d = 1'b1;
              st_d   = S_RD;
            end else begin
              drv_d = 1'b0;
              st_d  = S_WR;
            end
          end
        end
        S_WR: begin
          if (rise) begin
            sh_d  = {sh_q[6:0], sda_s_q};
            bit_d = bit_q + 4'h1;
          end else if (fall && bit_q == 4'h8) begin
            if (wcnt_q < CMD_PRM_BYTES) begin
              wbuf_d[wcnt_q[2:0]] = sh_q;
            end
            // saturates so an overlong write never decodes
            wcnt_d  = (wcnt_q == 4'hF) ? wcnt_q : wcnt_q + 4'h1;
            wrote_d = 1'b1;
            drv_d   = 1'b1;
            st_d    = S_WACK;
          end
        end
        S_WACK: begin
          if (fall) begin
            drv_d = 1'b0;
            bit_d = 4'h0;
            st_d  = S_WR;
          end
        end
        S_RD: begin
          if (fall) begin
            if (bit_q == 4'h7) begin
              drv_d = 1'b0;
              st_d  = S_MACK;
            end else begin
              sh_d  = {sh_q[6:0], 1'b0};
              drv_d = ~sh_q[6];
              bit_d = bit_q + 4'h1;
            end
          end
        end
        S_MACK: begin
          if (rise) begin
            st_d = sda_s_q ? S_IGN : S_MNEXT;
          end
        end
        S_MNEXT: begin
          if (fall) begin
            sh_d   = nxt_byte;
            drv_d  = ~nxt_byte[7];
            ridx_d = (ridx_q < RESP_WORD3) ? ridx_q + 4'h1 : ridx_q;
            bit_d  = 4'h0;
            st_d   = S_RD;
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st_q    <= S_IDLE;
      op_q    <= OP_PU;
      cnt_q   <= PU_CYC;
      bit_q   <= 4'h0;
      wcnt_q  <= 4'h0;
      rlen_q  <= 4'h0;
      ridx_q  <= 4'h0;
      sh_q    <= 8'h00;
      wbuf_q  <= '{default: 8'h00};
      resp_q  <= '{default: 8'h00};
      rw_q    <= 1'b0;
      drv_q   <= 1'b0;
      wrote_q <= 1'b0;
      read_q  <= 1'b0;
      meas_q  <= 1'b0;
      comp_q  <= 1'b0;
      rh_q    <= RH_DEFAULT;
      t_q     <= T_DEFAULT;
    end else begin
      st_q    <= st_d;
      op_q    <= op_d;
      cnt_q   <= cnt_d;
      bit_q   <= bit_d;
      wcnt_q  <= wcnt_d;
      rlen_q  <= rlen_d;
      ridx_q  <= ridx_d;
      sh_q    <= sh_d;
      wbuf_q  <= wbuf_d;
      resp_q  <= resp_d;
      rw_q    <= rw_d;
      drv_q   <= drv_d;
      wrote_q <= wrote_d;
      read_q  <= read_d;
      meas_q  <= meas_d;
      comp_q  <= comp_d;
      rh_q    <= rh_d;
      t_q     <= t_d;
    end
  end

  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oen = ~drv_q;
  // hotplate runs during the test and keeps its mode afterwards
  assign heater_on_out    = meas_q | (op_q == OP_SELF);
  assign comp_en_out      = comp_q;
  assign busy_out         = busy;
  assign rh_word_out      = rh_q;
  assign temp_word_out    = t_q;
endmodule // gsc_dev
`default_nettype wire

/* shared/gsc_pkg.sv */
// package: constants, command codes and crc for the gas sensor command port
`default_nettype none
package gsc_pkg;
  localparam int          CLK_PERIOD_NS = 4;
  localparam logic [6:0]  DEV_ADDR      = 7'h59;
  localparam logic [15:0] CMD_RAW       = 16'h260F;
  localparam logic [15:0] CMD_SELF      = 16'h280E;
  localparam logic [15:0] CMD_HEAT_OFF  = 16'h3615;
  localparam logic [15:0] CMD_SERIAL    = 16'h3682;
  localparam logic [15:0] RH_DEFAULT    = 16'h8000;
  localparam logic [15:0] T_DEFAULT     = 16'h6666;
  localparam logic [7:0]  CRC_POLY      = 8'h31;
  localparam logic [7:0]  CRC_INIT      = 8'hFF;
  localparam logic [7:0]  CRC_XOR       = 8'h00;
  localparam logic [15:0] SELF_PASS     = 16'hD400;
  localparam logic [7:0]  FILL_BYTE     = 8'hFF;
  localparam logic [3:0]  CMD_BYTES     = 4'h2;
  localparam logic [3:0]  CMD_PRM_BYTES = 4'h8;
  localparam logic [3:0]  RESP_WORD1    = 4'h3;
  localparam logic [3:0]  RESP_WORD3    = 4'h9;
  localparam int          RESP_MAX      = 9;
  // longest times, rounded down to whole cycles
  localparam int MEAS_TIME_NS  = 30_000_000;
  localparam int SELF_TIME_NS  = 320_000_000;
  localparam int SER_TIME_NS   = 1_000_000;
  localparam int HEAT_TIME_NS  = 1_000_000;
  localparam int PU_TIME_NS    = 600_000;
  localparam int MEAS_CYC_DEF  = MEAS_TIME_NS / CLK_PERIOD_NS;
  localparam int SELF_CYC_DEF  = SELF_TIME_NS / CLK_PERIOD_NS;
  localparam int SER_CYC_DEF   = SER_TIME_NS / CLK_PERIOD_NS;
  localparam int HEAT_CYC_DEF  = HEAT_TIME_NS / CLK_PERIOD_NS;
  localparam int PU_CYC_DEF    = PU_TIME_NS / CLK_PERIOD_NS;
  // least scl period (400 kHz), quarter rounded up
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QTR_CYC   = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c ^ CRC_XOR;
  endfunction
endpackage
`default_nettype wire

/* shared/gsc_if.sv */
// interface: open-drain two-wire link between host and sensor ends
`timescale 1ns/100ps
`default_nettype none
interface gsc_if;
  logic host_scl_out;
  logic host_scl_oen;
  logic host_sda_out;
  logic host_sda_oen;
  logic dev_sda_out;
  logic dev_sda_oen;
  logic scl_line;
  logic sda_line;
  // pulled high unless some end drives low
  assign scl_line = host_scl_oen | host_scl_out;
  assign sda_line = (host_sda_oen | host_sda_out) & (dev_sda_oen | dev_sda_out);
  modport dev_mp (input scl_line, input sda_line, output dev_sda_out, output dev_sda_oen);
  modport host_mp (input sda_line, output host_scl_out, output host_scl_oen,
                   output host_sda_out, output host_sda_oen);
endinterface
`default_nettype wire

/* core/gsc_host.sv */
// host end: two-wire master that writes commands and reads answers
`timescale 1ns/100ps
`default_nettype none
module gsc_host
  import gsc_pkg::*;
#(
  parameter int unsigned QTR_CYC = SCL_QTR_CYC
) (
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  gsc_if.host_mp           link,
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic        req_read_in,
  input  wire logic [15:0] req_cmd_in,
  input  wire logic        req_with_param_in,
  input  wire logic [15:0] req_rh_in,
  input  wire logic [15:0] req_temp_in,
  input  wire logic [3:0]  req_rd_len_in,
  output logic             rx_valid_out,
  output logic [7:0]       rx_data_out,
  output logic             done_out,
  output logic             nack_out
);
  typedef enum {H_IDLE, H_START, H_BIT, H_STOP} gsc_hst_t;

  gsc_hst_t    st_q, st_d;
  logic [31:0] div_q, div_d;
  logic [1:0]  ph_q, ph_d;
  logic [3:0]  bit_q, bit_d, byte_q, byte_d, last_q, last_d;
  logic        rd_q, rd_d, prm_q, prm_d, scl_q, scl_d, sda_q, sda_d;
  logic        nack_q, nack_d, retry_q, retry_d, rxv_q, rxv_d, done_q, done_d;
  logic [15:0] cmd_q, cmd_d, rh_q, rh_d, t_q, t_d;
  logic [7:0]  rx_q, rx_d, rxo_q, rxo_d, txb;
  logic        sda_m_q, sda_s_q, tick, sending;

  always_ff @(posedge core_clk_in) begin
    sda_m_q <= link.sda_line;
    sda_s_q <= sda_m_q;
  end

  always_comb begin
    case (byte_q)
      4'h0: txb = {DEV_ADDR, rd_q};
      4'h1: txb = cmd_q[15:8];
      4'h2: txb = cmd_q[7:0];
      4'h3: txb = rh_q[15:8];
      4'h4: txb = rh_q[7:0];
      4'h5: txb = crc8(rh_q);
      4'h6: txb = t_q[15:8];
      4'h7: txb = t_q[7:0];
      4'h8: txb = crc8(t_q);
      default: txb = FILL_BYTE;
    endcase
  end

  // scl runs from a quarter-period divider, at most 400 kHz with the default QTR_CYC
  assign tick    = (div_q == QTR_CYC - 1);
  assign sending = (byte_q == 4'h0) || !rd_q;

  always_comb begin
    st_d    = st_q;
    div_d   = (st_q == H_IDLE || tick) ? 32'h0000_0000 : div_q + 32'h0000_0001;
    ph_d    = ph_q;
    bit_d   = bit_q;
    byte_d  = byte_q;
    last_d  = last_q;
    rd_d    = rd_q;
    prm_d   = prm_q;
    scl_d   = scl_q;
    sda_d   = sda_q;
    nack_d  = nack_q;
    retry_d = retry_q;
    cmd_d   = cmd_q;
    rh_d    = rh_q;
    t_d     = t_q;
    rx_d    = rx_q;
    rxo_d   = rxo_q;
    rxv_d   = 1'b0;
    done_d  = 1'b0;
    case (st_q)
      H_IDLE: begin
        if (req_valid_in) begin
          rd_d   = req_read_in;
          prm_d  = req_with_param_in;
          cmd_d  = req_cmd_in;
          rh_d   = req_rh_in;
          t_d    = req_temp_in;
          last_d = req_read_in ? req_rd_len_in
                 : (req_with_param_in ? CMD_PRM_BYTES : CMD_BYTES);
          nack_d = 1'b0;
          ph_d   = 2'h0;
          st_d   = H_START;
        end
      end
      H_START: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          case (ph_q)
            2'h0: begin
              sda_d = 1'b1;
              scl_d = 1'b1;
            end
            2'h1: sda_d = 1'b0;
            default: begin
              scl_d   = 1'b0;
              ph_d    = 2'h0;
              bit_d   = 4'h0;
              byte_d  = 4'h0;
              retry_d = 1'b0;
              st_d    = H_BIT;
            end
          endcase
        end
      end
      H_BIT: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          case (ph_q)
            2'h0: begin
              if (bit_q != 4'h8) begin
                sda_d = sending ? txb[3'h7 - bit_q[2:0]] : 1'b1;
              end else begin
                // ack every byte but the last one read
                sda_d = sending || byte_q == last_q;
              end
            end
            2'h1: scl_d = 1'b1;
            2'h2: begin
              if (bit_q != 4'h8) begin
                rx_d = {rx_q[6:0], sda_s_q};
              end else if (sending) begin
                if (sda_s_q) begin
                  nack_d  = ~rd_q;
                  // device busy: poll the read header again
                  retry_d = rd_q;
                end
              end else begin
                rxo_d = rx_q;
                rxv_d = 1'b1;
              end
            end
            default: begin
              scl_d = 1'b0;
              if (bit_q != 4'h8) begin
                bit_d = bit_q + 4'h1;
              end else if (nack_q || retry_q || byte_q == last_q) begin
                ph_d = 2'h0;
                st_d = H_STOP;
              end else begin
                bit_d  = 4'h0;
                byte_d = byte_q + 4'h1;
              end
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_d = 1'b0;
            2'h1: scl_d = 1'b1;
            2'h2: sda_d = 1'b1;
            default: begin
              ph_d   = 2'h0;
              st_d   = retry_q ? H_START : H_IDLE;
              done_d = ~retry_q;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st_q    <= H_IDLE;
      div_q   <= 32'h0000_0000;
      ph_q    <= 2'h0;
      bit_q   <= 4'h0;
      byte_q  <= 4'h0;
      last_q  <= 4'h0;
      rd_q    <= 1'b0;
      prm_q   <= 1'b0;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      nack_q  <= 1'b0;
      retry_q <= 1'b0;
      cmd_q   <= 16'h0000;
      rh_q    <= RH_DEFAULT;
      t_q     <= T_DEFAULT;
      rx_q    <= 8'h00;
      rxo_q   <= 8'h00;
      rxv_q   <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      div_q   <= div_d;
      ph_q    <= ph_d;
      bit_q   <= bit_d;
      byte_q  <= byte_d;
      last_q  <= last_d;
      rd_q    <= rd_d;
      prm_q   <= prm_d;
      scl_q   <= scl_d;
      sda_q   <= sda_d;
      nack_q  <= nack_d;
      retry_q <= retry_d;
      cmd_q   <= cmd_d;
      rh_q    <= rh_d;
      t_q     <= t_d;
      rx_q    <= rx_d;
      rxo_q   <= rxo_d;
      rxv_q   <= rxv_d;
      done_q  <= done_d;
    end
  end

  assign link.host_scl_out = 1'b0;
  assign link.host_scl_oen = scl_q;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oen = sda_q;
  assign req_ready_out     = (st_q == H_IDLE);
  assign rx_valid_out      = rxv_q;
  assign rx_data_out       = rxo_q;
  assign done_out          = done_q;
  assign nack_out          = nack_q;
endmodule // gsc_host
`default_nettype wire

/* verif/gsc_props.sv */
// checker: timing and ownership of the two-wire link lines
`timescale 1ns/100ps
`default_nettype none
module gsc_props #(
  parameter int unsigned QTR_CYC = 16
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic host_scl_out,
  input wire logic host_scl_oen,
  input wire logic host_sda_out,
  input wire logic host_sda_oen,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oen,
  input wire logic scl_line,
  input wire logic sda_line
);
  // two quarters per scl level, less slack for sync jitter
  localparam int HALF_MIN = 2 * QTR_CYC - 2;
  logic        scl_q;
  logic        sda_q;
  logic        bus_q;
  logic [15:0] run_q;
  logic        start_w;
  logic        stop_w;
  assign start_w = scl_q & scl_line & sda_q & ~sda_line;
  assign stop_w  = scl_q & scl_line & ~sda_q & sda_line;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bus_q <= 1'b0;
      run_q <= 16'h0000;
    end else begin
      scl_q <= scl_line;
      sda_q <= sda_line;
      bus_q <= start_w | (bus_q & ~stop_w);
      run_q <= (scl_line != scl_q) ? 16'h0001 : run_q + {15'h0000, ~&run_q};
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  chk_pins_open_drain: assert property (!host_scl_out && !host_sda_out && !dev_sda_out)
    else $error("driven pin value not low");
  chk_dev_data_stable: assert property (scl_q && scl_line |-> $stable(dev_sda_oen))
    else $error("device moved sda while scl high");
  chk_start_by_host: assert property (start_w |-> !host_sda_oen)
    else $error("start not made by host");
  chk_stop_by_host: assert property (stop_w |-> $rose(host_sda_oen))
    else $error("stop not made by host");
  chk_scl_half_time: assert property (scl_line != scl_q |-> run_q >= HALF_MIN)
    else $error("scl level too short");
  chk_start_hold: assert property (start_w |-> (scl_line && !sda_line) [*8])
    else $error("start hold too short");
  chk_stop_idle: assert property (stop_w |-> (scl_line && sda_line) [*8])
    else $error("bus free time too short");
  chk_dev_quiet_idle: assert property (!bus_q |-> dev_sda_oen)
    else $error("device drives idle bus");
  cov_start: cover property (start_w);
  cov_stop: cover property (stop_w);
  cov_dev_drive: cover property (bus_q && $fell(dev_sda_oen));
endmodule // gsc_props
`default_nettype wire

/* verif/gas_sensor_i2c_command_port_tb.sv */
// testbench: host and sensor ends joined over the link
`timescale 1ns/100ps
`default_nettype none
module gas_sensor_i2c_command_port_tb;
  import gsc_pkg::*;
  // arbitrary value
  localparam logic [47:0] SER = 48'hA5C3_0F1E_7788;
  // link quarter period shared by the host and the checker
  localparam int unsigned QTR = 16;
  logic [15:0] raw = 16'hBEEF;
  logic        rdy;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        vld = 1'b0;
  logic        rd = 1'b0;
  logic        wp = 1'b0;
  logic [15:0] cmd = 16'h0000;
  logic [15:0] rh = 16'h0000;
  logic [15:0] tw = 16'h0000;
  logic [3:0]  len = 4'h0;
  logic        rxv, done, nack, heat, comp, busy;
  logic [7:0]  rxd;
  logic [15:0] rh_o, t_o;
  logic [71:0] got;
  int          n_errors = 0;
  int          n_checks = 0;
  gsc_if lnk();
  // self-test kept long so a write can land while it runs
  gsc_dev #(.MEAS_CYC(200), .SELF_CYC(3000), .SER_CYC(50), .HEAT_CYC(20), .PU_CYC(50),
    .SERIAL_NUM(SER)) gsc_dev_inst (.core_clk_in(clk), .sys_rst_in(rst), .link(lnk),
    .raw_gas_signal_in(raw), .heater_on_out(heat), .comp_en_out(comp),
    .busy_out(busy), .rh_word_out(rh_o), .temp_word_out(t_o));
  gsc_host #(.QTR_CYC(QTR)) gsc_host_inst (.core_clk_in(clk), .sys_rst_in(rst), .link(lnk),
    .req_valid_in(vld), .req_ready_out(rdy), .req_read_in(rd), .req_cmd_in(cmd),
    .req_with_param_in(wp), .req_rh_in(rh), .req_temp_in(tw), .req_rd_len_in(len),
    .rx_valid_out(rxv), .rx_data_out(rxd), .done_out(done), .nack_out(nack));
  gsc_props #(.QTR_CYC(QTR)) gsc_props_inst (.core_clk_in(clk), .sys_rst_in(rst),
    .host_scl_out(lnk.host_scl_out), .host_scl_oen(lnk.host_scl_oen),
    .host_sda_out(lnk.host_sda_out), .host_sda_oen(lnk.host_sda_oen),
    .dev_sda_out(lnk.dev_sda_out), .dev_sda_oen(lnk.dev_sda_oen),
    .scl_line(lnk.scl_line), .sda_line(lnk.sda_line));
  ////////////////////////////////////////
  function automatic logic [23:0] pk(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    end
    return {w, c};
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] seen);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bytes shift into got, which starts all ones
  task automatic xfer(input logic r, input logic [15:0] c, input logic p,
                      input logic [15:0] h, input logic [15:0] t, input logic [3:0] n);
    int k;
    got = '1;
    vld <= 1'b1;
    rd <= r;
    cmd <= c;
    wp <= p;
    rh <= h;
    tw <= t;
    len <= n;
    @(posedge clk);
    vld <= 1'b0;
    for (k = 0; k < 40000 && done !== 1'b1; k++) begin
      @(posedge clk);
      if (rxv === 1'b1) got = {got[63:0], rxd};
    end
    if (done !== 1'b1) begin
      chk("done", 1'b1, done);
      summarize();
    end
    chk("ready", 1'b1, rdy);
  endtask
  task automatic wr(input logic [15:0] c, input logic p, input logic [15:0] h,
                    input logic [15:0] t);
    xfer(1'b0, c, p, h, t, 4'h0);
  endtask
  task automatic rdn(input logic [3:0] n);
    xfer(1'b1, 16'h0000, 1'b0, 16'h0000, 16'h0000, n);
  endtask
  ////////////////////////////////////////
  task automatic t_powerup();
    int k;
    for (k = 0; k < 60 && busy !== 1'b0; k++) @(posedge clk);
    chk("busy_pu", {1'b0, 1'b0}, {busy, heat});
    if (busy !== 1'b0) summarize();
  endtask
  task automatic t_serial();
    wr(CMD_SERIAL, 1'b0, 16'h0000, 16'h0000);
    chk("nack", 1'b0, nack);
    rdn(4'h9);
    chk("serial", {pk(SER[47:32]), pk(SER[31:16]), pk(SER[15:0])}, got);
    rdn(4'h2);
    chk("reread", 16'hFFFF, got[15:0]);
  endtask
  task automatic t_measure();
    wr(CMD_RAW, 1'b1, RH_DEFAULT, T_DEFAULT);
    rdn(4'h4);
    chk("raw", {16'hBEEF, 8'h92, 8'hFF}, got[31:0]);
    chk("mode", {1'b1, 1'b0}, {heat, comp});
    // a fresh sensing value shows the second measurement really ran
    raw <= 16'h1357;
    wr(CMD_RAW, 1'b1, 16'h1234, 16'h5678);
    wr(16'h1234, 1'b0, 16'h0000, 16'h0000);
    rdn(4'h1);
    chk("raw_hi", 8'h13, got[7:0]);
    rdn(4'h3);
    chk("once", 24'hFF_FFFF, got[23:0]);
    chk("prm", {16'h1234, 16'h5678, 1'b1}, {rh_o, t_o, comp});
  endtask
  task automatic t_self();
    wr(CMD_SELF, 1'b0, 16'h0000, 16'h0000);
    wr(CMD_HEAT_OFF, 1'b0, 16'h0000, 16'h0000);
    chk("busy_nack", 1'b1, nack);
    rdn(4'h3);
    chk("self", pk(SELF_PASS), got[23:0]);
    chk("heat_kept", 1'b1, heat);
    wr(CMD_HEAT_OFF, 1'b0, 16'h0000, 16'h0000);
    rdn(4'h1);
    chk("off", {8'hFF, 1'b0}, {got[7:0], heat});
    wr(CMD_SELF, 1'b0, 16'h0000, 16'h0000);
    rdn(4'h3);
    chk("self_idle", {pk(SELF_PASS), 1'b0}, {got[23:0], heat});
  endtask
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_powerup();
    t_serial();
    t_measure();
    t_self();
    summarize();
  end
endmodule // gas_sensor_i2c_command_port_tb
`default_nettype wire
